// *** core/slcd_ctrl.sv ***
// Segment LCD controller with APB registers, display RAM and panel drive.
//
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/100ps
module slcd_ctrl
    import slcd_pkg::*;
#(
    parameter int NSEG = slcd_pkg::NUM_SEG
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Count sources and power mode.
    input wire logic prescaler_output_clock,
    input wire logic timer5_bit4_tap,
    input wire logic ram_backup_mode,
    // Panel drive, two-bit level code per pin.
    output logic [2*slcd_pkg::NUM_COM-1:0] com_level,
    output logic [2*NSEG-1:0] seg_level,
    // Supply pin and power circuit control.
    output logic [2:0] shared_segment_outputs,
    output logic [2:0] lcd_supply_inputs,
    output logic internal_supply_used,
    output logic internal_divider_on,
    output logic divider_low_resistance
);
    import slcd_pkg::*;

    if (NSEG != NUM_SEG) begin : g_bad_nseg
        $error("slcd_ctrl: only twenty segments are supported.");
    end

    logic [3:0] timer_control_six_ff;
    logic [3:0] lcd_divider_timer_ff;
    logic [3:0] lcd_control_first_ff;
    logic [3:0] lcd_control_second_ff;
    logic [NUM_COM-1:0] ram_ff [NSEG];
    logic [1:0] com_idx_ff;
    logic [1:0] nxt_com_idx;
    logic pol_ff;
    logic nxt_pol;
    logic [2*NUM_COM-1:0] com_level_ff;
    logic [2*NUM_COM-1:0] nxt_com_level;
    logic [2*NSEG-1:0] seg_level_ff;
    logic [2*NSEG-1:0] nxt_seg_level;
    logic [31:0] prdata_ff;
    logic [31:0] nxt_prdata;
    logic pslverr_ff;
    logic lcd_clk;
    logic lcd_tick;

    // APB decode; the slave always answers in the first access cycle.
    wire logic acc = psel && penable;
    wire logic wr = acc && pwrite;
    wire logic [11:0] ram_off = paddr - OFF_RAM_BASE;
    wire logic [9:0] ram_word = ram_off[11:2];
    wire logic hit_ram = (paddr >= OFF_RAM_BASE) && (ram_word < 10'(NSEG))
        && (paddr[1:0] == 2'b00);
    wire logic hit_tc = paddr == OFF_TIMER_CTL;
    wire logic hit_div = paddr == OFF_DIVIDER;
    wire logic hit_ctl1 = paddr == OFF_LCD_CTL1;
    wire logic hit_ctl2 = paddr == OFF_LCD_CTL2;
    wire logic hit_st = paddr == OFF_STATUS;
    wire logic hit_any = hit_ram || hit_tc || hit_div || hit_ctl1 || hit_ctl2 || hit_st;
    wire logic [4:0] ram_sel = ram_word[4:0];

    // Duty decode and scan length.
    wire slcd_duty_e duty = slcd_duty_e'(lcd_control_first_ff[1:0]);
    wire logic duty_ok = duty != DUTY_NONE;
    wire logic third_bias = (duty == DUTY_THIRD) || (duty == DUTY_QUARTER);
    wire logic [1:0] last_com = (duty == DUTY_HALF) ? 2'h1 :
        (duty == DUTY_THIRD) ? 2'h2 : 2'h3;
    wire logic blank = ram_backup_mode || !lcd_control_first_ff[BIT_LCD_ON] || !duty_ok;
    wire logic frame_end = lcd_tick && (com_idx_ff >= last_com);

    // Non-selected levels depend on bias; half bias uses the first supply both ways.
    wire logic [1:0] lvl_sel_com = pol_ff ? LVL_VSS : LVL_V3;
    wire logic [1:0] lvl_on_seg = pol_ff ? LVL_V3 : LVL_VSS;
    wire logic [1:0] lvl_mid_com = (third_bias && pol_ff) ? LVL_V2 : LVL_V1;
    wire logic [1:0] lvl_off_seg = (third_bias && !pol_ff) ? LVL_V2 : LVL_V1;

    slcd_clkdiv #(
        .DIV_W(DIV_W)
    ) u_clkdiv (
        .pclk(pclk),
        .presetn(presetn),
        .src_sel(timer_control_six_ff[BIT_SRC_SEL]),
        .enable(timer_control_six_ff[BIT_DIV_EN]),
        .divider(lcd_divider_timer_ff),
        .prescaler_output_clock(prescaler_output_clock),
        .timer5_bit4_tap(timer5_bit4_tap),
        .lcd_clk(lcd_clk),
        .lcd_tick(lcd_tick)
    );

    // Scan position and frame polarity; polarity flips each frame to keep DC off the panel.
    assign nxt_com_idx = blank ? 2'h0 : frame_end ? 2'h0 :
        lcd_tick ? com_idx_ff + 2'h1 : com_idx_ff;
    assign nxt_pol = blank ? 1'b0 : frame_end ? !pol_ff : pol_ff;

    genvar gc;
    generate
        for (gc = 0; gc < NUM_COM; gc++) begin : g_com
            // Commons beyond the duty stay at the mid level and may be left open.
            assign nxt_com_level[2*gc +: 2] = blank ? LVL_V3 :
                (com_idx_ff == 2'(gc)) ? lvl_sel_com : lvl_mid_com;
        end
        for (gc = 0; gc < NSEG; gc++) begin : g_seg
            assign nxt_seg_level[2*gc +: 2] = blank ? LVL_V3 :
                ram_ff[gc][com_idx_ff] ? lvl_on_seg : lvl_off_seg;
        end
    endgenerate

    assign nxt_prdata = !hit_any ? 32'h0 :
        hit_ram ? {28'h0, ram_ff[ram_sel]} :
        hit_tc ? {28'h0, timer_control_six_ff} :
        hit_div ? {28'h0, lcd_divider_timer_ff} :
        hit_ctl1 ? {28'h0, lcd_control_first_ff} :
        hit_ctl2 ? {28'h0, lcd_control_second_ff} :
        {28'h0, blank, lcd_clk, com_idx_ff} | {27'h0, pol_ff, 4'h0};

    // Pin sharing: a cleared second-register bit turns a supply pin into a segment.
    assign shared_segment_outputs = ~lcd_control_second_ff[3:1];
    assign lcd_supply_inputs = lcd_control_second_ff[3:1];
    assign internal_supply_used = |shared_segment_outputs;
    assign internal_divider_on = !lcd_control_second_ff[BIT_INT_RES_OFF] || internal_supply_used;
    assign divider_low_resistance = lcd_control_first_ff[BIT_RES_SEL];
    assign com_level = com_level_ff;
    assign seg_level = seg_level_ff;
    assign prdata = prdata_ff;
    assign pready = 1'b1;
    assign pslverr = pslverr_ff && acc;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_control_six_ff <= RST_TIMER_CTL;
            lcd_divider_timer_ff <= RST_DIVIDER;
            lcd_control_first_ff <= RST_LCD_CTL1;
            lcd_control_second_ff <= RST_LCD_CTL2;
        end else if (wr) begin
            if (hit_tc) timer_control_six_ff <= pwdata[3:0];
            if (hit_div) lcd_divider_timer_ff <= pwdata[3:0];
            if (hit_ctl1) lcd_control_first_ff <= pwdata[3:0];
            if (hit_ctl2) lcd_control_second_ff <= pwdata[3:0];
        end
    end

    // Display RAM keeps its contents through reset; only the drive is blanked.
    always_ff @(posedge pclk) begin
        if (wr && hit_ram) ram_ff[ram_sel] <= pwdata[NUM_COM-1:0];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            com_idx_ff <= 2'h0;
            pol_ff <= 1'b0;
            com_level_ff <= {NUM_COM{LVL_V3}};
            seg_level_ff <= {NSEG{LVL_V3}};
        end else begin
            com_idx_ff <= nxt_com_idx;
            pol_ff <= nxt_pol;
            com_level_ff <= nxt_com_level;
            seg_level_ff <= nxt_seg_level;
        end
    end

    // Read data and error are registered in the setup cycle, ready at the access edge.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0;
            pslverr_ff <= 1'b0;
        end else if (psel && !penable) begin
            prdata_ff <= pwrite ? 32'h0 : nxt_prdata;
            pslverr_ff <= !hit_any;
        end
    end
endmodule

// *** core/slcd_pkg.sv ***
// Shared constants for the segment LCD controller.
package slcd_pkg;
    localparam int NUM_COM = 4;
    localparam int NUM_SEG = 20;
    localparam int DIV_W = 4;
    // Register byte offsets.
    localparam logic [11:0] OFF_TIMER_CTL = 12'h000;
    localparam logic [11:0] OFF_DIVIDER = 12'h004;
    localparam logic [11:0] OFF_LCD_CTL1 = 12'h008;
    localparam logic [11:0] OFF_LCD_CTL2 = 12'h00c;
    localparam logic [11:0] OFF_STATUS = 12'h010;
    localparam logic [11:0] OFF_RAM_BASE = 12'h040;
    // Field positions.
    localparam int BIT_SRC_SEL = 2;
    localparam int BIT_DIV_EN = 3;
    localparam int BIT_RES_SEL = 3;
    localparam int BIT_LCD_ON = 2;
    localparam int BIT_INT_RES_OFF = 0;
    // Reset values.
    localparam logic [3:0] RST_TIMER_CTL = 4'h0;
    localparam logic [3:0] RST_DIVIDER = 4'h0;
    localparam logic [3:0] RST_LCD_CTL1 = 4'h0;
    localparam logic [3:0] RST_LCD_CTL2 = 4'hf;
    // Drive level codes: ground, first, second and top LCD supply.
    localparam logic [1:0] LVL_VSS = 2'h0;
    localparam logic [1:0] LVL_V1 = 2'h1;
    localparam logic [1:0] LVL_V2 = 2'h2;
    localparam logic [1:0] LVL_V3 = 2'h3;
    typedef enum logic [1:0] {
        DUTY_NONE = 2'b00,
        DUTY_HALF = 2'b01,
        DUTY_THIRD = 2'b10,
        DUTY_QUARTER = 2'b11
    } slcd_duty_e;
endpackage

// *** core/slcd_clkdiv.sv ***
// LCD clock divider: source select, gating and divide by (value+1) then 2.
`timescale 1ns/100ps
module slcd_clkdiv #(
    parameter int DIV_W = 4
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Control.
    input wire logic src_sel,
    input wire logic enable,
    input wire logic [DIV_W-1:0] divider,
    // Count sources.
    input wire logic prescaler_output_clock,
    input wire logic timer5_bit4_tap,
    // Output.
    output logic lcd_clk,
    output logic lcd_tick
);
    if (DIV_W < 1 || DIV_W > 8) begin : g_bad_width
        $error("slcd_clkdiv: DIV_W out of range.");
    end

    logic src_ff;
    logic nxt_src;
    logic [DIV_W-1:0] cnt_ff;
    logic [DIV_W-1:0] nxt_cnt;
    logic clk_ff;
    logic nxt_clk;
    wire logic src_level = src_sel ? prescaler_output_clock : timer5_bit4_tap;
    wire logic src_edge = enable && src_level && !src_ff;
    wire logic wrap = src_edge && (cnt_ff >= divider);

    assign nxt_src = src_level;
    // The count clears and no edge is counted while disabled, so the LCD clock freezes.
    assign nxt_cnt = !enable ? '0 : wrap ? '0 : src_edge ? cnt_ff + 1'b1 : cnt_ff;
    assign nxt_clk = wrap ? !clk_ff : clk_ff;
    assign lcd_clk = clk_ff;
    assign lcd_tick = wrap && clk_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_ff <= 1'b0;
            cnt_ff <= '0;
            clk_ff <= 1'b0;
        end else begin
            src_ff <= nxt_src;
            cnt_ff <= nxt_cnt;
            clk_ff <= nxt_clk;
        end
    end
endmodule

// *** tb/slcd_ctrl_assertions.sv ***
// Port-level assertions for the segment LCD controller.
`timescale 1ns/100ps
module slcd_ctrl_assertions
    import slcd_pkg::*;
#(
    parameter int NSEG = 20
) (
    // Clock, reset and bus.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    // Power mode and panel drive.
    input wire logic ram_backup_mode,
    input wire logic [2*NUM_COM-1:0] com_level,
    input wire logic [2*NSEG-1:0] seg_level,
    // Supply pin and power circuit control.
    input wire logic [2:0] shared_segment_outputs,
    input wire logic [2:0] lcd_supply_inputs,
    input wire logic internal_supply_used,
    input wire logic internal_divider_on,
    input wire logic divider_low_resistance
);
    // Shadow of the first control register, tracked from bus writes.
    logic [3:0] ctl1_ff;
    logic [2:0] nsel;
    wire logic wr_ctl1 = psel && penable && pwrite && paddr == OFF_LCD_CTL1;
    wire logic wr_ctl2 = psel && penable && pwrite && paddr == OFF_LCD_CTL2;
    wire logic blank = &com_level && &seg_level;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl1_ff <= 4'h0;
        end else if (wr_ctl1) begin
            ctl1_ff <= pwdata[3:0];
        end
    end
    always_comb begin
        nsel = 3'h0;
        for (int c = 0; c < NUM_COM; c++) begin
            nsel = nsel + 3'(com_level[2*c+:2] inside {2'h0, 2'h3});
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Three settled cycles let the registered drive catch up with a new setting.
    sequence s_shown(logic [1:0] d);
        (ctl1_ff[2:0] == {1'b1, d} && !ram_backup_mode) [*3];
    endsequence
    property p_backup_blank; ram_backup_mode |=> blank; endproperty
    property p_duty_none; wr_ctl1 && pwdata[1:0] == 2'h0 |-> ##[1:2] blank; endproperty
    property p_lcd_off; wr_ctl1 && !pwdata[2] |-> ##[1:2] blank; endproperty
    property p_pins_write; wr_ctl2 |=> lcd_supply_inputs == $past(pwdata[3:1]); endproperty
    property p_pins_split; shared_segment_outputs == ~lcd_supply_inputs; endproperty
    property p_int_supply; internal_supply_used == |shared_segment_outputs; endproperty
    property p_int_divider; internal_supply_used |-> internal_divider_on; endproperty
    property p_half_coms;
        s_shown(2'h1) |-> com_level[7:4] inside {4'h5, 4'h6, 4'h9, 4'ha};
    endproperty
    property p_res_sel; wr_ctl1 |=> divider_low_resistance == $past(pwdata[3]); endproperty
    property p_third_com; s_shown(2'h2) |-> com_level[7:6] inside {2'h1, 2'h2}; endproperty
    property p_one_common; s_shown(2'h3) |-> nsel == 3'h1; endproperty
    a_backup_blank: assert property (p_backup_blank) else $error("drive not blanked");
    a_duty_none: assert property (p_duty_none) else $error("duty 00 shows");
    a_lcd_off: assert property (p_lcd_off) else $error("LCD off shows");
    a_pins_write: assert property (p_pins_write) else $error("pin mode wrong");
    a_pins_split: assert property (p_pins_split) else $error("pin split wrong");
    a_int_supply: assert property (p_int_supply) else $error("supply flag wrong");
    a_int_divider: assert property (p_int_divider) else $error("divider off");
    a_half_coms: assert property (p_half_coms) else $error("half duty com");
    a_third_com: assert property (p_third_com) else $error("third duty com");
    a_one_common: assert property (p_one_common) else $error("not one common");
    a_res_sel: assert property (p_res_sel) else $error("resistor select wrong");
endmodule
bind slcd_ctrl slcd_ctrl_assertions #(.NSEG(NSEG)) u_slcd_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .ram_backup_mode(ram_backup_mode), .paddr(paddr), .pwdata(pwdata), .com_level(com_level),
    .seg_level(seg_level), .shared_segment_outputs(shared_segment_outputs),
    .lcd_supply_inputs(lcd_supply_inputs), .internal_supply_used(internal_supply_used),
    .internal_divider_on(internal_divider_on),
    .divider_low_resistance(divider_low_resistance)
);

// *** tb/slcd_panel_model.sv ***
// Passive panel model: reports which crossings see the full supply span.
`timescale 1ns/100ps
module slcd_panel_model #(
    parameter int NSEG = 20
) (
    input wire logic [7:0] com_level,
    input wire logic [2*NSEG-1:0] seg_level,
    output logic [4*NSEG-1:0] lit
);
    always_comb begin
        for (int c = 0; c < 4; c++) begin
            for (int s = 0; s < NSEG; s++) begin
                // Mid levels never light a pixel, whatever the polarity.
                lit[c*NSEG+s] = {com_level[2*c+:2], seg_level[2*s+:2]} inside {4'h3, 4'hc};
            end
        end
    end
endmodule

// *** tb/tb_segment_lcd_controller.sv ***
// Self-checking bench for the segment LCD controller.
`timescale 1ns/100ps
module tb_segment_lcd_controller;
    import slcd_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pre = 0, tap = 0, bkup = 0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, seed = 32'h4a6f;
    logic pready, pslverr;
    logic [7:0] com_level;
    logic [39:0] seg_level;
    logic [79:0] lit, exp_lit;
    logic [3:0] ram [20];
    logic [32:0] q [$];
    int bad_count = 0, cmp_count = 0, s, k, d, dv, src;
    slcd_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .prescaler_output_clock(pre), .timer5_bit4_tap(tap),
        .ram_backup_mode(bkup), .com_level(com_level), .seg_level(seg_level),
        .shared_segment_outputs(), .lcd_supply_inputs(), .internal_supply_used(),
        .internal_divider_on(), .divider_low_resistance());
    slcd_panel_model u_panel (.com_level(com_level), .seg_level(seg_level), .lit(lit));
    initial forever #20 pclk = ~pclk;
    task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    function automatic logic [3:0] rnd4();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[3:0];
    endfunction
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    // Each source pulse is two clocks wide so the sampled edge cannot be missed.
    task automatic pulse(input int sel, input int n);
        repeat (n) begin
            pre <= sel == 1;
            tap <= sel == 0;
            repeat (2) @(posedge pclk);
            pre <= 1'b0;
            tap <= 1'b0;
            repeat (2) @(posedge pclk);
        end
    endtask
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) begin
            chk(80'({pslverr, prdata}), 80'(q.pop_front()));
        end
    end
    initial begin
        #400_000;
        bad_count++;
        complete_run();
    end
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk(80'({com_level, seg_level}), 80'hff_ffff_ffff_ff);
        rd(OFF_LCD_CTL1, 33'h0);
        rd(OFF_LCD_CTL2, 33'hf);
        rd(12'h020, 33'h1_0000_0000);
        $display("Reset test done");
        for (s = 0; s < 20; s++) apb(1'b1, OFF_RAM_BASE + 12'(4 * s), 32'(rnd4()));
        seed = 32'h4a6f;
        for (s = 0; s < 20; s++) ram[s] = rnd4();
        apb(1'b1, OFF_LCD_CTL2, 32'h0);
        for (d = 1; d < 4; d++) begin
            dv = rnd4() % 3;
            src = d % 2;
            apb(1'b1, OFF_LCD_CTL1, 32'h0);
            apb(1'b1, OFF_TIMER_CTL, 32'h0);
            apb(1'b1, OFF_DIVIDER, 32'(dv));
            rd(OFF_DIVIDER, 33'(dv));
            apb(1'b1, OFF_TIMER_CTL, 32'(8 + 4 * src));
            apb(1'b1, OFF_LCD_CTL1, 32'(4 + d));
            // The registered drive shows the new setting one edge after the write settles.
            @(posedge pclk);
            for (k = 0; k < 2 * (d + 1) + 1; k++) begin
                exp_lit = '0;
                for (s = 0; s < 20; s++) exp_lit[(k % (d + 1)) * 20 + s] = ram[s][k % (d + 1)];
                chk(lit, exp_lit);
                pulse(1 - src, 2 * (dv + 1));
                chk(lit, exp_lit);
                pulse(src, 2 * (dv + 1));
            end
            $display("Duty test %0d done", d);
        end
        apb(1'b1, OFF_LCD_CTL1, 32'hc);
        @(posedge pclk);
        chk(80'(com_level), 80'hff);
        apb(1'b1, OFF_LCD_CTL1, 32'h7);
        // With the divider disabled, source edges must not move the scan off common 0.
        apb(1'b1, OFF_TIMER_CTL, 32'h4);
        exp_lit = '0;
        for (s = 0; s < 20; s++) exp_lit[s] = ram[s][0];
        pulse(1, 4);
        chk(lit, exp_lit);
        bkup <= 1'b1;
        repeat (2) @(posedge pclk);
        chk(80'(seg_level), 80'hff_ffff_ffff);
        $display("Blanking test done");
        complete_run();
    end
endmodule
